// ===== lcq_pkg.sv
// Constants, types and template store for the label class-of-service qbin scheduler.
package lcq_pkg;

  localparam int NQ = 6;
  localparam int NCONN = 16;
  localparam int LBL_W = 4;
  localparam int PAY_W = 32;
  localparam int QDEPTH = 4;
  localparam int QAW = 2;
  localparam int QCW = 3;
  localparam int WT_W = 7;

  localparam logic [3:0] QBIN_BASE = 4'ha;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DROPS = 8'h08;
  localparam logic [7:0] ADDR_CONN = 8'h0c;
  localparam logic [7:0] ADDR_QSEL = 8'h10;
  localparam logic [7:0] ADDR_QCFG = 8'h14;

  localparam int CONN_LABEL_LSB = 16;
  localparam int CONN_SETUP_BIT = 31;
  localparam int QCFG_MAX_LSB = 0;
  localparam int QCFG_CLPHI_LSB = 4;
  localparam int QCFG_CLPLO_LSB = 8;
  localparam int QCFG_EFCI_LSB = 12;
  localparam int QCFG_EPD_LSB = 16;
  localparam int QCFG_WT_LSB = 24;
  localparam int STATUS_NONEMPTY_LSB = 8;
  localparam int STATUS_BLOCK_LSB = 16;

  localparam logic [15:0] SVC_NULL = 16'h0000;
  localparam logic [15:0] SVC_DEFAULT = 16'h0001;
  localparam logic [15:0] SVC_SIGNAL = 16'h0002;
  localparam logic [15:0] SVC_LABEL_BASE = 16'h0200;
  localparam logic [15:0] SVC_LABEL_LAST = 16'h0207;
  localparam logic [15:0] SVC_LABEL_ABR = 16'h0210;

  localparam logic [2:0] QI_SIGNAL = 3'h0;
  localparam logic [2:0] QI_DEFAULT = 3'h3;
  localparam logic [2:0] QI_ABR = 3'h4;

  localparam logic [WT_W-1:0] WT_MAX = 7'h64;
  localparam logic [WT_W-1:0] WT_CLS0 = 7'h32;
  localparam logic [WT_W-1:0] WT_CLS1 = 7'h32;
  localparam logic [WT_W-1:0] WT_CLS2 = 7'h00;
  localparam logic [WT_W-1:0] WT_CLS3 = 7'h01;
  localparam logic [WT_W-1:0] WT_OTHER = 7'h01;

  localparam logic [QCW-1:0] TH_MAX = 3'h4;
  localparam logic [QCW-1:0] TH_CLPHI = 3'h3;
  localparam logic [QCW-1:0] TH_CLPLO = 3'h1;
  localparam logic [QCW-1:0] TH_EFCI = 3'h2;
  localparam logic [QCW-1:0] TH_EPD = 3'h4;

  typedef struct packed {
    logic [LBL_W-1:0] label;
    logic clp;
    logic [PAY_W-1:0] payload;
  } lcq_cell_t;

  typedef struct packed {
    logic [LBL_W-1:0] label;
    logic clp;
    logic efci;
    logic [3:0] qbin;
    logic [PAY_W-1:0] payload;
  } lcq_out_cell_t;

  typedef struct packed {
    logic [QCW-1:0] max_th;
    logic [QCW-1:0] clphi_th;
    logic [QCW-1:0] clplo_th;
    logic [QCW-1:0] efci_th;
    logic [QCW-1:0] epd_th;
    logic [WT_W-1:0] weight;
  } lcq_qcfg_t;

  typedef struct packed {
    logic valid;
    logic [2:0] qidx;
    logic police;
  } lcq_conn_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } lcq_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lcq_apb_rsp_t;

  // Template store: service type in, per-connection parameters and qbin index out.
  function automatic lcq_conn_t lcq_template(input logic [15:0] svc);
    lcq_conn_t t;
    t = '0;
    if (svc == SVC_DEFAULT) begin
      t = '{valid: 1'b1, qidx: QI_DEFAULT, police: 1'b1};
    end else if (svc == SVC_SIGNAL) begin
      t = '{valid: 1'b1, qidx: QI_SIGNAL, police: 1'b0};
    end else if (svc >= SVC_LABEL_BASE && svc <= SVC_LABEL_LAST) begin
      t = '{valid: 1'b1, qidx: {1'b0, svc[1:0]}, police: 1'b0};
    end else if (svc == SVC_LABEL_ABR) begin
      t = '{valid: 1'b1, qidx: QI_ABR, police: 1'b0};
    end
    return t;
  endfunction

  function automatic lcq_qcfg_t lcq_default_qcfg(input logic [2:0] qi);
    lcq_qcfg_t c;
    c.max_th = TH_MAX;
    c.clphi_th = TH_CLPHI;
    c.clplo_th = TH_CLPLO;
    c.efci_th = TH_EFCI;
    c.epd_th = TH_EPD;
    case (qi)
      3'h0: c.weight = WT_CLS0;
      3'h1: c.weight = WT_CLS1;
      3'h2: c.weight = WT_CLS2;
      3'h3: c.weight = WT_CLS3;
      default: c.weight = WT_OTHER;
    endcase
    return c;
  endfunction

endpackage

// ===== lcq_scheduler.sv
// Label class-of-service classifier, qbins 10 to 15 and weighted scheduler with APB registers.
//
// Operation
// - Label traffic uses only qbins 10 to 15.
// - Qbins 0 to 9 never receive label cells.
// - Label cos 0-7 map to qbin 10 plus class mod 4.
// - Label ABR type goes to qbin 14.
// - Default to 13, signaling to 10, null invalid.
// - Activating interface assigns default label template.
// - Setup indexes template store by service type.
// - Template holds per-connection and qbin groups.
// - Qbin config: max, clp hi/lo, efci, epd, weight.
// - Each cell looked up by its label.
// - Qbins buffer cells, served as bandwidth allows.
// - Bandwidth split by weight, unused share redistributed.
// - Default weights 50, 50, 0, 1.
// - Weights limited to 100.
// - Four label circuits per source-destination pair.
// - Templates loaded when interface first configured.
// - CLP bit splits each class in two.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module lcq_scheduler
  import lcq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire lcq_apb_req_t apb_req_i,
  output lcq_apb_rsp_t apb_rsp_o,
  input wire logic cell_in_valid_i,
  input wire lcq_cell_t cell_in_i,
  output logic cell_in_ready_o,
  output logic cell_out_valid_o,
  input wire logic cell_out_ready_i,
  output lcq_out_cell_t cell_out_o
);

  typedef struct packed {
    logic active;
    logic [31:0] prdata;
    logic [2:0] qsel;
    logic [15:0] drops;
    logic [31:0] conn_result;
    lcq_qcfg_t [NQ-1:0] qcfg;
    lcq_conn_t [NCONN-1:0] conn;
    lcq_cell_t [NQ-1:0][QDEPTH-1:0] mem;
    logic [NQ-1:0][QAW-1:0] rd_ptr;
    logic [NQ-1:0][QAW-1:0] wr_ptr;
    logic [NQ-1:0][QCW-1:0] cnt;
    logic [NQ-1:0] clp_block;
    logic [NQ-1:0][WT_W-1:0] credit;
    logic [2:0] rr;
    logic out_valid;
    lcq_out_cell_t out_cell;
  } lcq_state_t;

  lcq_state_t st;
  lcq_state_t next_st;

  logic apb_setup;
  logic apb_write;
  logic addr_hit;

  // Register map, one aligned 32-bit word per register:
  // Control at 0x00 holds the active bit; a write of 1 while idle loads the defaults.
  // Status at 0x04 shows active in bit 0, qbin backlog in 13:8 and CLP discard in 21:16.
  // The drop counter at 0x08 is 16 bits wide, saturates, and clears on any write.
  // Connection at 0x0c takes the type in 15:0, the label in 19:16 and set-up in bit 31.
  // Its read returns the last result as valid, qbin index and policing bits.
  // Qbin select at 0x10 names qbin 10 to 15 as index 0 to 5.
  // Qbin config at 0x14 holds the thresholds in 3-bit fields and the weight from bit 24.
  // Unmapped offsets answer with an error in the access cycle and change nothing.
  // The slave answers in the first access cycle; read data was captured in setup.
  assign apb_setup = apb_req_i.psel && !apb_req_i.penable;
  assign apb_write = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  assign addr_hit = (apb_req_i.paddr == ADDR_CTRL) || (apb_req_i.paddr == ADDR_STATUS) ||
                    (apb_req_i.paddr == ADDR_DROPS) || (apb_req_i.paddr == ADDR_CONN) ||
                    (apb_req_i.paddr == ADDR_QSEL) || (apb_req_i.paddr == ADDR_QCFG);

  assign apb_rsp_o.prdata = st.prdata;
  assign apb_rsp_o.pready = 1'b1;
  assign apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable && !addr_hit;

  // The output stage holds one cell until the sink takes it; the next cell is
  // loaded only in a cycle in which that slot frees.
  // Overflow is handled by discard, so the input never back-pressures.
  assign cell_in_ready_o = !rst_i;
  assign cell_out_valid_o = st.out_valid;
  assign cell_out_o = st.out_cell;

  function automatic logic [WT_W-1:0] clamp_weight(input logic [7:0] w);
    if (w > {1'b0, WT_MAX}) begin
      return WT_MAX;
    end
    return w[WT_W-1:0];
  endfunction

  // Default weight of one qbin, taken from its default configuration.
  function automatic logic [WT_W-1:0] default_weight(input logic [2:0] qi);
    lcq_qcfg_t c;
    c = lcq_default_qcfg(qi);
    return c.weight;
  endfunction

  always_comb begin
    lcq_conn_t ce;
    lcq_conn_t tmpl;
    logic [2:0] q;
    logic [2:0] pick;
    logic [2:0] idx;
    logic eff_clp;
    logic drop;
    logic found;
    logic deq;
    logic enq;
    logic slot_free;
    logic [NQ-1:0] nonempty;
    logic [NQ-1:0] elig;
    logic [NQ-1:0][QCW-1:0] cnt_now;
    lcq_cell_t head;
    logic [31:0] rd;
    ce = '0;
    tmpl = '0;
    q = '0;
    pick = '0;
    idx = '0;
    eff_clp = 1'b0;
    drop = 1'b0;
    found = 1'b0;
    deq = 1'b0;
    enq = 1'b0;
    slot_free = 1'b0;
    nonempty = '0;
    elig = '0;
    head = '0;
    rd = '0;
    next_st = st;
    cnt_now = st.cnt;

    // Register writes.
    if (apb_write) begin
      case (apb_req_i.paddr)
        ADDR_CTRL: begin
          if (apb_req_i.pwdata[0] && !st.active) begin
            // Port or trunk brought up: the default label template and its qbin
            // settings are loaded into the port logic.
            for (int i = 0; i < NQ; i++) begin
              next_st.qcfg[i] = lcq_default_qcfg(3'(i));
              next_st.credit[i] = default_weight(3'(i));
            end
          end
          next_st.active = apb_req_i.pwdata[0];
        end
        ADDR_DROPS: begin
          next_st.drops = '0;
        end
        ADDR_CONN: begin
          // The template store maps each service type to its qbin and policing;
          // every label carries its own type, so sibling circuits may differ.
          tmpl = lcq_template(apb_req_i.pwdata[15:0]);
          idx = '0;
          if (!st.active) begin
            next_st.conn_result = '0;
          end else if (apb_req_i.pwdata[CONN_SETUP_BIT]) begin
            // Setup completes only with a valid template; null and unknown
            // types leave the label unbound.
            next_st.conn[apb_req_i.pwdata[CONN_LABEL_LSB +: LBL_W]] = tmpl;
            next_st.conn_result = {27'h0, tmpl};
          end else begin
            next_st.conn[apb_req_i.pwdata[CONN_LABEL_LSB +: LBL_W]] = '0;
            next_st.conn_result = '0;
          end
        end
        ADDR_QSEL: begin
          // Out-of-range selects are ignored, so the config window always names a qbin.
          if (apb_req_i.pwdata[2:0] < 3'(NQ)) begin
            next_st.qsel = apb_req_i.pwdata[2:0];
          end
        end
        ADDR_QCFG: begin
          next_st.qcfg[st.qsel].max_th = apb_req_i.pwdata[QCFG_MAX_LSB +: QCW];
          next_st.qcfg[st.qsel].clphi_th = apb_req_i.pwdata[QCFG_CLPHI_LSB +: QCW];
          next_st.qcfg[st.qsel].clplo_th = apb_req_i.pwdata[QCFG_CLPLO_LSB +: QCW];
          next_st.qcfg[st.qsel].efci_th = apb_req_i.pwdata[QCFG_EFCI_LSB +: QCW];
          next_st.qcfg[st.qsel].epd_th = apb_req_i.pwdata[QCFG_EPD_LSB +: QCW];
          next_st.qcfg[st.qsel].weight =
            clamp_weight(apb_req_i.pwdata[QCFG_WT_LSB +: 8]);
        end
        default: begin
        end
      endcase
    end

    // A backlogged qbin with credit left is eligible; backlog alone counts once no backlogged qbin has credit.
    for (int i = 0; i < NQ; i++) begin
      nonempty[i] = st.cnt[i] != '0;
      elig[i] = nonempty[i] && (st.credit[i] != '0);
    end

    // Scheduler: weighted round robin over qbins 10 to 15. A qbin with credit
    // left goes first; when no backlogged qbin has credit, credits reload and any backlogged
    // qbin may send, so a share left idle flows to the others.
    // A qbin of weight 0 sends only when every backlogged peer has spent its
    // credit, so it may starve behind busy ones.
    slot_free = !st.out_valid || cell_out_ready_i;
    if (slot_free) begin
      next_st.out_valid = 1'b0;
    end
    if (slot_free && (nonempty != '0)) begin
      found = 1'b0;
      for (int k = 1; k <= NQ; k++) begin
        idx = 3'((32'(st.rr) + 32'(k)) % NQ);
        if (!found && elig[idx]) begin
          found = 1'b1;
          pick = idx;
        end
      end
      if (!found) begin
        for (int i = 0; i < NQ; i++) begin
          next_st.credit[i] = st.qcfg[i].weight;
        end
        for (int k = 1; k <= NQ; k++) begin
          idx = 3'((32'(st.rr) + 32'(k)) % NQ);
          if (!found && nonempty[idx]) begin
            found = 1'b1;
            pick = idx;
          end
        end
      end
      deq = found;
    end
    // Ring pointers wrap at the qbin depth by their own width, so no compare is
    // needed; the count alone tells full from empty.
    if (deq) begin
      head = st.mem[pick][st.rd_ptr[pick]];
      if (next_st.credit[pick] != '0) begin
        next_st.credit[pick] = next_st.credit[pick] - 1'b1;
      end
      next_st.rr = pick;
      next_st.rd_ptr[pick] = st.rd_ptr[pick] + 1'b1;
      cnt_now[pick] = st.cnt[pick] - 1'b1;
      next_st.out_valid = 1'b1;
      next_st.out_cell.label = head.label;
      next_st.out_cell.clp = head.clp;
      next_st.out_cell.payload = head.payload;
      // EFCI marks congestion from the depth seen at dequeue, this cell included.
      next_st.out_cell.efci = st.cnt[pick] >= st.qcfg[pick].efci_th;
      next_st.out_cell.qbin = QBIN_BASE + {1'b0, pick};
    end

    // Ingress classification and admission. Admission sees the count after this
    // cycle's dequeue, so a full qbin that sends a cell may take one in the same cycle.
    if (cell_in_valid_i && !rst_i) begin
      ce = st.conn[cell_in_i.label];
      q = ce.qidx;
      // Policed connections send every cell as low priority, first to go under CLP discard.
      eff_clp = cell_in_i.clp || ce.police;
      if (!st.active || !ce.valid) begin
        drop = 1'b1;
      end else if (cnt_now[q] >= st.qcfg[q].max_th ||
                   cnt_now[q] >= 3'(QDEPTH)) begin
        drop = 1'b1;
      end else if (eff_clp && st.clp_block[q]) begin
        drop = 1'b1;
      end else if (!eff_clp && cnt_now[q] >= st.qcfg[q].epd_th) begin
        drop = 1'b1;
      end
      enq = !drop;
      // A drop in the cycle of a clear write counts on top of the clear, so no
      // refused cell goes unrecorded.
      if (drop && next_st.drops != 16'hffff) begin
        next_st.drops = next_st.drops + 1'b1;
      end
    end
    // The cell stores its CLP after policing, so the output shows the priority
    // the qbin really applied.
    if (enq) begin
      next_st.mem[q][st.wr_ptr[q]] = '{label: cell_in_i.label, clp: eff_clp,
                                       payload: cell_in_i.payload};
      next_st.wr_ptr[q] = st.wr_ptr[q] + 1'b1;
      cnt_now[q] = cnt_now[q] + 1'b1;
    end

    // CLP discard engages at the high threshold and releases at the low one,
    // which keeps low-priority cells from flapping in and out near one level.
    for (int i = 0; i < NQ; i++) begin
      next_st.cnt[i] = cnt_now[i];
      if (cnt_now[i] >= st.qcfg[i].clphi_th) begin
        next_st.clp_block[i] = 1'b1;
      end else if (cnt_now[i] <= st.qcfg[i].clplo_th) begin
        next_st.clp_block[i] = 1'b0;
      end
    end

    // Read data is captured in the setup cycle and presented in the access cycle.
    if (apb_setup && !apb_req_i.pwrite) begin
      case (apb_req_i.paddr)
        ADDR_CTRL: rd = {31'h0, st.active};
        ADDR_STATUS: begin
          rd[0] = st.active;
          rd[STATUS_NONEMPTY_LSB +: NQ] = nonempty;
          rd[STATUS_BLOCK_LSB +: NQ] = st.clp_block;
        end
        ADDR_DROPS: rd = {16'h0, st.drops};
        ADDR_CONN: rd = st.conn_result;
        ADDR_QSEL: rd = {29'h0, st.qsel};
        ADDR_QCFG: begin
          rd[QCFG_MAX_LSB +: QCW] = st.qcfg[st.qsel].max_th;
          rd[QCFG_CLPHI_LSB +: QCW] = st.qcfg[st.qsel].clphi_th;
          rd[QCFG_CLPLO_LSB +: QCW] = st.qcfg[st.qsel].clplo_th;
          rd[QCFG_EFCI_LSB +: QCW] = st.qcfg[st.qsel].efci_th;
          rd[QCFG_EPD_LSB +: QCW] = st.qcfg[st.qsel].epd_th;
          rd[QCFG_WT_LSB +: WT_W] = st.qcfg[st.qsel].weight;
        end
        default: rd = '0;
      endcase
      next_st.prdata = rd;
    end
  end

  // Reset restores the default weights and thresholds, so the qbins are sane
  // even before the interface is first brought up.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '0;
      for (int i = 0; i < NQ; i++) begin
        st.qcfg[i] <= lcq_default_qcfg(3'(i));
        st.credit[i] <= default_weight(3'(i));
      end
    end else begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

// ===== lcq_props.sv
// Port checker for the label qbin scheduler.
`timescale 1ns/1ps
`default_nettype none
module lcq_props
  import lcq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire lcq_apb_req_t apb_req_i,
  input wire lcq_apb_rsp_t apb_rsp_o,
  input wire logic cell_in_valid_i,
  input wire lcq_cell_t cell_in_i,
  input wire logic cell_in_ready_o,
  input wire logic cell_out_valid_o,
  input wire logic cell_out_ready_i,
  input wire lcq_out_cell_t cell_out_o
);
  logic act;
  logic on_seen;
  logic [15:0] svc [NCONN];
  logic wr;
  logic [3:0] q;
  function automatic logic [3:0] exp_q(input logic [15:0] s);
    if (s == 16'h0001) return 4'hd;
    if (s == 16'h0002) return 4'ha;
    if (s >= 16'h0200 && s <= 16'h0207) return 4'ha + {2'b00, s[1:0]};
    if (s == 16'h0210) return 4'he;
    return 4'h0;
  endfunction
  assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  assign q = exp_q(svc[cell_out_o.label]);
  // Binding is only tracked while active, as the block ignores setup otherwise.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      act <= 1'b0;
      on_seen <= 1'b0;
      svc <= '{default: '0};
    end else if (wr && apb_req_i.paddr == ADDR_CTRL) begin
      act <= apb_req_i.pwdata[0];
      on_seen <= on_seen | apb_req_i.pwdata[0];
    end else if (wr && act && apb_req_i.paddr == ADDR_CONN) begin
      svc[apb_req_i.pwdata[19:16]] <= apb_req_i.pwdata[31] ? apb_req_i.pwdata[15:0] : 16'h0000;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence acc_s;
    apb_req_i.psel && apb_req_i.penable;
  endsequence
  sequence unmapped_s;
    acc_s ##0 (apb_req_i.paddr > 8'h14 || apb_req_i.paddr[1:0] != 2'b00);
  endsequence
  apb_ready_a: assert property (acc_s |-> apb_rsp_o.pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (unmapped_s |-> apb_rsp_o.pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (acc_s ##0 (apb_req_i.paddr == ADDR_QCFG) |-> !apb_rsp_o.pslverr)
    else $error("error on qbin config access");
  legacy_free_a: assert property (cell_out_valid_o |-> cell_out_o.qbin >= QBIN_BASE)
    else $error("cell in legacy qbin");
  qbin_range_a: assert property (cell_out_valid_o |-> cell_out_o.qbin <= 4'he)
    else $error("cell in qbin without service type");
  qbin_map_a: assert property (cell_out_valid_o |-> cell_out_o.qbin == q)
    else $error("cell in wrong qbin");
  police_a: assert property (cell_out_valid_o && svc[cell_out_o.label] == SVC_DEFAULT |-> cell_out_o.clp)
    else $error("policed cell lost clp");
  out_hold_a: assert property (cell_out_valid_o && !cell_out_ready_i |=> cell_out_valid_o && $stable(cell_out_o))
    else $error("output cell not held");
  quiet_a: assert property (!on_seen |-> !cell_out_valid_o)
    else $error("cell out before activation");
  in_ready_a: assert property (!rst_i |-> cell_in_ready_o)
    else $error("input not ready");
endmodule
bind lcq_scheduler lcq_props u_props (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o),
  .cell_in_valid_i(cell_in_valid_i),
  .cell_in_i(cell_in_i),
  .cell_in_ready_o(cell_in_ready_o),
  .cell_out_valid_o(cell_out_valid_o),
  .cell_out_ready_i(cell_out_ready_i),
  .cell_out_o(cell_out_o)
);
`default_nettype wire

// ===== lcq_edge_model.sv
// Edge router model that offers labelled cells to the scheduler.
`timescale 1ns/1ps
`default_nettype none
module lcq_edge_model
  import lcq_pkg::*;
(
  input wire logic core_clk_i,
  output logic valid_o,
  output lcq_cell_t cell_o
);
  initial begin
    valid_o = 1'b0;
    cell_o = '0;
  end
  // Idle data shows the inverse of the last cell, so a stale value never looks valid.
  task automatic send(input logic [LBL_W-1:0] lbl, input logic clp, input logic [PAY_W-1:0] pay);
    lcq_cell_t c;
    c = '{label: lbl, clp: clp, payload: pay};
    @(posedge core_clk_i);
    valid_o <= 1'b1;
    cell_o <= c;
    @(posedge core_clk_i);
    valid_o <= 1'b0;
    cell_o <= ~c;
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the label qbin scheduler.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lcq_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  lcq_apb_req_t req = '0;
  lcq_apb_rsp_t rsp;
  logic in_v;
  lcq_cell_t in_c;
  logic in_r;
  logic out_v;
  logic out_r = 1'b1;
  lcq_out_cell_t out_c;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;
  logic ef;
  logic [6:0] wt [NQ] = '{7'h32, 7'h32, 7'h00, 7'h01, 7'h01, 7'h01};
  logic [15:0] svc [13] = '{16'h0001, 16'h0002, 16'h0200, 16'h0201, 16'h0202, 16'h0203,
    16'h0204, 16'h0205, 16'h0206, 16'h0207, 16'h0210, 16'h0000, 16'h0300};
  logic [7:0] wr_w [4] = '{8'h31, 8'h64, 8'h65, 8'hff};
  logic [6:0] ex_w [4] = '{7'h31, 7'h64, 7'h64, 7'h64};
  always #12.5 core_clk_i = ~core_clk_i;
  lcq_scheduler u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .cell_in_valid_i(in_v), .cell_in_i(in_c), .cell_in_ready_o(in_r),
    .cell_out_valid_o(out_v), .cell_out_ready_i(out_r), .cell_out_o(out_c));
  lcq_edge_model u_edge (.core_clk_i(core_clk_i), .valid_o(in_v), .cell_o(in_c));
  function automatic logic [3:0] qb(input logic [15:0] s);
    if (s == 16'h0001) return 4'hd;
    if (s == 16'h0002) return 4'ha;
    if (s >= 16'h0200 && s <= 16'h0207) return 4'ha + {2'b00, s[1:0]};
    if (s == 16'h0210) return 4'he;
    return 4'h0;
  endfunction
  function automatic logic [31:0] res(input logic [15:0] s);
    logic [3:0] q;
    q = qb(s);
    return {27'h0, q != 4'h0, (q != 4'h0) ? q[2:0] - 3'h2 : 3'h0, s == 16'h0001};
  endfunction
  function automatic logic [31:0] cfgw(input logic [6:0] w);
    return {1'b0, w, 24'h042134};
  endfunction
  task automatic stop_test();
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk_i);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge core_clk_i);
    req.penable <= 1'b1;
    do @(posedge core_clk_i); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(a, 1'b0, 32'h0);
    cmp(rd, exp, m);
  endtask
  task automatic take(input logic [3:0] l, input logic [3:0] q, input logic c,
                      input logic [31:0] p);
    int t;
    t = 0;
    @(negedge core_clk_i);
    while (out_v !== 1'b1 && t < 50) begin
      @(negedge core_clk_i);
      t++;
    end
    ef = out_c.efci;
    cmp({out_v, out_c.label, out_c.qbin, out_c.clp, out_c.payload}, {1'b1, l, q, c, p}, "cell");
    @(posedge core_clk_i);
  endtask
  initial begin
    #100us;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rdc(ADDR_CTRL, 32'h0, "ctrl");
    for (int i = 0; i < NQ; i++) begin
      apb(ADDR_QSEL, 1'b1, 32'(i));
      rdc(ADDR_QCFG, cfgw(wt[i]), "qcfg");
    end
    rdc(8'h18, 32'h0, "unmapped");
    cmp(err, 1'b1, "slverr");
    apb(ADDR_CONN, 1'b1, 32'h8001_0002);
    rdc(ADDR_CONN, 32'h0, "conn inactive");
    u_edge.send(4'h1, 1'b0, 32'h0);
    rdc(ADDR_DROPS, 32'h1, "drop inactive");
    apb(ADDR_DROPS, 1'b1, 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    rdc(ADDR_STATUS, 32'h1, "active");
    for (int i = 0; i < 13; i++) begin
      apb(ADDR_CONN, 1'b1, {1'b1, 11'h0, 4'(i), svc[i]});
      rdc(ADDR_CONN, res(svc[i]), "setup");
    end
    for (int i = 0; i < 13; i++) begin
      u_edge.send(4'(i), i[0], 32'h100 + 32'(i));
      if (qb(svc[i]) != 4'h0)
        take(4'(i), qb(svc[i]), i[0] | (i == 0), 32'h100 + 32'(i));
    end
    rdc(ADDR_DROPS, 32'h2, "invalid drop");
    apb(ADDR_DROPS, 1'b1, 32'h0);
    // One cell waits in the output stage, four fill qbin 10, the sixth is refused.
    out_r <= 1'b0;
    for (int i = 0; i < 6; i++) u_edge.send(4'h2, 1'b0, 32'h300 + 32'(i));
    for (int i = 0; i < 2; i++) u_edge.send(4'h4, 1'b0, 32'h200 + 32'(i));
    rdc(ADDR_DROPS, 32'h1, "full drop");
    rdc(ADDR_STATUS, 32'h0001_0501, "full status");
    out_r <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      take(4'h2, 4'ha, 1'b0, 32'h300 + 32'(i));
      if (i == 1) cmp(ef, 1'b1, "efci set");
      if (i == 4) cmp(ef, 1'b0, "efci clear");
    end
    for (int i = 0; i < 2; i++) take(4'h4, 4'hc, 1'b0, 32'h200 + 32'(i));
    apb(ADDR_QSEL, 1'b1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(ADDR_QCFG, 1'b1, {wr_w[i], 24'h042134});
      rdc(ADDR_QCFG, cfgw(ex_w[i]), "weight");
    end
    apb(ADDR_CONN, 1'b1, 32'h0002_0200);
    u_edge.send(4'h2, 1'b0, 32'h0);
    rdc(ADDR_DROPS, 32'h2, "teardown drop");
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rdc(ADDR_CTRL, 32'h0, "ctrl again");
    stop_test();
  end
endmodule
`default_nettype wire
